/* File: core/ioex_link_side.sv */
`default_nettype none

// Link-clock half: keeps the command pointer and hands events to the core.
module ioex_link_side
    import ioex_pkg::*;
(
    // Link clock and reset request coming from the core domain.
    input wire logic sclClk,
    input wire logic coreResetActive,
    // Events from the serial protocol engine, on the link clock.
    input wire logic cmdStrobe,
    input wire logic [7:0] cmdByte,
    input wire logic dataStrobe,
    input wire logic [7:0] dataByte,
    input wire logic ownReadAck,
    input wire logic foreignReadAck,
    // Held words and event toggles towards the core domain.
    output logic [1:0] pointerHeld,
    output logic [1:0] writeSelHeld,
    output logic [7:0] writeDataHeld,
    output logic pointerToggle,
    output logic writeToggle,
    output logic clearToggle,
    output logic linkReady
);
    typedef struct packed {
        logic [1:0] rst;
        logic [1:0] ptr;
        logic [1:0] wSel;
        logic [7:0] wData;
        logic pTog;
        logic wTog;
        logic cTog;
        logic ready;
    } ioex_link_state_type;

    ioex_link_state_type linkState_reg;
    ioex_link_state_type linkState_next;

    // Next state: pointer, write capture and clear requests.
    always_comb
    begin
        linkState_next = linkState_reg;
        linkState_next.rst = {linkState_reg.rst[0], coreResetActive};
        linkState_next.ready = !linkState_reg.rst[1];
        if (linkState_reg.rst[1])
        begin
            linkState_next.ptr = REG_INPUT;
            linkState_next.wSel = REG_INPUT;
            linkState_next.wData = DATA_RESET;
            linkState_next.pTog = 1'b0;
            linkState_next.wTog = 1'b0;
            linkState_next.cTog = 1'b0;
        end
        else
        begin
            // The pointer changes only on a new command byte.
            if (cmdStrobe)
            begin
                linkState_next.ptr = cmdByte[1:0];
                linkState_next.pTog = !linkState_reg.pTog;
            end
            if (dataStrobe)
            begin
                linkState_next.wSel = linkState_reg.ptr;
                linkState_next.wData = dataByte;
                linkState_next.wTog = !linkState_reg.wTog;
            end
            // Any acknowledged read address clears while the pointer is zero.
            if ((ownReadAck || foreignReadAck) && linkState_reg.ptr == REG_INPUT)
            begin
                linkState_next.cTog = !linkState_reg.cTog;
            end
        end
    end

    // State register on the link clock.
    always_ff @(posedge sclClk)
    begin
        linkState_reg <= linkState_next;
    end

    // Outputs straight from the state register.
    assign pointerHeld = linkState_reg.ptr;
    assign writeSelHeld = linkState_reg.wSel;
    assign writeDataHeld = linkState_reg.wData;
    assign pointerToggle = linkState_reg.pTog;
    assign writeToggle = linkState_reg.wTog;
    assign clearToggle = linkState_reg.cTog;
    assign linkReady = linkState_reg.ready;

    // Checks on the link clock.
    default clocking linkCk @(posedge sclClk);
    endclocking
    default disable iff (linkState_reg.rst[1]);

    a_pointer_hold: assert property (!cmdStrobe |=> pointerHeld == $past(pointerHeld))
        else $error("Pointer moved without a command byte.");
    a_pointer_bits: assert property (cmdStrobe |=> pointerHeld == $past(cmdByte[1:0]))
        else $error("Pointer does not hold the low command bits.");
    a_flaw_clear: assert property (foreignReadAck && pointerHeld == REG_INPUT
        |=> clearToggle != $past(clearToggle))
        else $error("Foreign read acknowledge with pointer zero did not clear.");
    c_flaw_seen: cover property (foreignReadAck && pointerHeld == REG_INPUT);
endmodule

`default_nettype wire

/* File: core/ioex_pkg.sv */
`default_nettype none

// Shared constants of the eight-bit port expander core.
package ioex_pkg;
    // Port width and command pointer values selecting the four registers.
    localparam int PORT_WIDTH = 8;
    localparam logic [1:0] REG_INPUT = 2'h0;
    localparam logic [1:0] REG_OUTPUT = 2'h1;
    localparam logic [1:0] REG_POLARITY = 2'h2;
    localparam logic [1:0] REG_DIRECTION = 2'h3;

    // Power-up values of the writable registers and the snapshot.
    localparam logic [7:0] OUTPUT_RESET = 8'hFF;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] SNAPSHOT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Core clock period and the longest allowed pin-to-alert time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALERT_VALID_NS = 4000;
    localparam int ALERT_VALID_CYC = ALERT_VALID_NS / CLK_PERIOD_NS;

    // Cycles after reset release while the snapshot follows the pins.
    localparam logic [1:0] PRIME_CYCLES = 2'h3;
endpackage

`default_nettype wire

/* File: core/ioex_port_alert.sv */
`default_nettype none

// Operation
// - Hold reset until supply passes threshold.
// - All eight pins start as inputs.
// - Input pins: both drivers off.
// - Output pins: output register picks driver.
// - Any input pin edge raises alert.
// - Alert drops when pins return.
// - Input register read clears at acknowledge.
// - Change during clearing acknowledge may vanish.
// - Later changes raise alert again.
// - Other bus traffic leaves alert alone.
// - Output pins never raise alert.
// - Output-to-input switch may raise alert.
// - Alert is active low open drain.
// - Pointer zero plus foreign read clears.
// - Pointer holds until next command byte.
// - Low two command bits select register.
// - Direction one means input, zero output.
// - Input register shows live pin levels.
// - Polarity bit inverts reported input of input pins only.
module ioex_port_alert
    import ioex_pkg::*;
(
    // Core clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Supply monitor level, high once the supply is above threshold.
    input wire logic powerOnThreshold,
    // Link clock and serial engine events on it.
    input wire logic sclClk,
    input wire logic cmdStrobe,
    input wire logic [7:0] cmdByte,
    input wire logic dataStrobe,
    input wire logic [7:0] dataByte,
    input wire logic ownReadAck,
    input wire logic foreignReadAck,
    // Expander pins.
    input wire logic [7:0] expanderPinsIn,
    output logic [7:0] expanderPinsOut,
    output logic [7:0] expanderPinsOe,
    output logic [7:0] highSideDriver,
    output logic [7:0] lowSideDriver,
    // Open-drain alert line.
    output logic alertOut,
    output logic alertOe,
    // Value of the register the pointer selects.
    output logic [7:0] readByte
);
    typedef struct packed {
        // Synchronisers and the reset request towards the link half.
        logic [1:0] thr;
        logic coreRst;
        logic [7:0] pin1;
        logic [7:0] pin2;
        logic [1:0] rdy;
        logic [2:0] pSync;
        logic [2:0] wSync;
        logic [2:0] cSync;
        // Pointer copy, registers and the change snapshot.
        logic [1:0] ptr;
        logic [7:0] outv;
        logic [7:0] pol;
        logic [7:0] dir;
        logic [7:0] snap;
        logic [1:0] prime;
        // Output stage, read-back and alert.
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] rd;
        logic alertOe;
    } ioex_core_state_type;

    ioex_core_state_type coreState_reg;
    ioex_core_state_type coreState_next;

    logic [1:0] pointerHeld;
    logic [1:0] writeSelHeld;
    logic [7:0] writeDataHeld;
    logic pointerToggle;
    logic writeToggle;
    logic clearToggle;
    logic linkReady;
    logic pointerEvent;
    logic writeEvent;
    logic clearEvent;
    logic [7:0] reportedInput;
    logic [7:0] changedInputs;

    // True when a synchronised toggle moved; bit 0 is never looked at.
    // A toggle survives a link clock that stops between frames, where a pulse could be missed.
    function automatic logic toggled(input logic [2:0] chain);
        toggled = chain[2] ^ chain[1];
    endfunction

    // Register selected for read-back by the pointer.
    function automatic logic [7:0] readValue(
        input logic [1:0] sel,
        input logic [7:0] inputVal,
        input logic [7:0] outVal,
        input logic [7:0] polVal,
        input logic [7:0] dirVal
    );
        case (sel)
            REG_INPUT: readValue = inputVal;
            REG_OUTPUT: readValue = outVal;
            REG_POLARITY: readValue = polVal;
            default: readValue = dirVal;
        endcase
    endfunction

    // Link-clock half: pointer, write words and clear requests.
    ioex_link_side linkSide (
        .sclClk(sclClk),
        .coreResetActive(coreState_reg.coreRst),
        .cmdStrobe(cmdStrobe),
        .cmdByte(cmdByte),
        .dataStrobe(dataStrobe),
        .dataByte(dataByte),
        .ownReadAck(ownReadAck),
        .foreignReadAck(foreignReadAck),
        .pointerHeld(pointerHeld),
        .writeSelHeld(writeSelHeld),
        .writeDataHeld(writeDataHeld),
        .pointerToggle(pointerToggle),
        .writeToggle(writeToggle),
        .clearToggle(clearToggle),
        .linkReady(linkReady)
    );

    // Link events count only once the link half has left reset.
    assign pointerEvent = coreState_reg.rdy[1] && toggled(coreState_reg.pSync);
    assign writeEvent = coreState_reg.rdy[1] && toggled(coreState_reg.wSync);
    assign clearEvent = coreState_reg.rdy[1] && toggled(coreState_reg.cSync);

    // Next state of the core.
    always_comb
    begin
        coreState_next = coreState_reg;
        // Two-flop synchronisers for pins, supply level and link toggles.
        coreState_next.thr = {coreState_reg.thr[0], powerOnThreshold};
        coreState_next.pin1 = expanderPinsIn;
        coreState_next.pin2 = coreState_reg.pin1;
        coreState_next.rdy = {coreState_reg.rdy[0], linkReady};
        coreState_next.pSync = {coreState_reg.pSync[1:0], pointerToggle};
        coreState_next.wSync = {coreState_reg.wSync[1:0], writeToggle};
        coreState_next.cSync = {coreState_reg.cSync[1:0], clearToggle};
        coreState_next.coreRst = !coreState_reg.thr[1];
        if (!coreState_reg.thr[1])
        begin
            // Supply below threshold: everything goes to power-up values.
            coreState_next.ptr = REG_INPUT;
            coreState_next.outv = OUTPUT_RESET;
            coreState_next.pol = POLARITY_RESET;
            coreState_next.dir = DIRECTION_RESET;
            coreState_next.snap = SNAPSHOT_RESET;
            coreState_next.prime = 2'h0;
        end
        else
        begin
            // Pointer copy for read-back.
            if (pointerEvent)
            begin
                coreState_next.ptr = pointerHeld;
            end
            // Register writes; writes aimed at the input register do nothing.
            if (writeEvent)
            begin
                case (writeSelHeld)
                    REG_OUTPUT: coreState_next.outv = writeDataHeld;
                    REG_POLARITY: coreState_next.pol = writeDataHeld;
                    REG_DIRECTION: coreState_next.dir = writeDataHeld;
                    default: coreState_next.outv = coreState_reg.outv;
                endcase
            end
            // Snapshot follows the pins until the synchronisers are full.
            // Otherwise the reset snapshot would raise a false alert after power-up.
            if (coreState_reg.prime != PRIME_CYCLES)
            begin
                coreState_next.prime = coreState_reg.prime + 2'h1;
                coreState_next.snap = coreState_reg.pin2;
            end
            else if (clearEvent)
            begin
                // A change landing in this cycle is absorbed by the new snapshot.
                coreState_next.snap = coreState_reg.pin2;
            end
        end
        // Drivers: input pins have both off, outputs follow the output register.
        coreState_next.pinOut = coreState_next.outv;
        coreState_next.pinOe = ~coreState_next.dir;
        coreState_next.hi = coreState_next.outv & ~coreState_next.dir;
        coreState_next.lo = ~coreState_next.outv & ~coreState_next.dir;
        // Live pin levels, inverted where polarity asks, for input pins.
        reportedInput = coreState_reg.pin2 ^ (coreState_next.pol & coreState_next.dir);
        // Difference to the snapshot, masked to input pins only.
        changedInputs = (coreState_reg.pin2 ^ coreState_next.snap) & coreState_next.dir;
        // Read-back of the selected register.
        coreState_next.rd = readValue(coreState_next.ptr, reportedInput, coreState_next.outv,
            coreState_next.pol, coreState_next.dir);
        // Alert while any input pin differs from the snapshot.
        coreState_next.alertOe = (coreState_next.prime == PRIME_CYCLES) && (|changedInputs);
    end

    // State register with synchronous reset.
    // Reset values match the power-up values, so no pin drives during reset.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            coreState_reg <= '0;
            coreState_reg.coreRst <= 1'b1;
            coreState_reg.outv <= OUTPUT_RESET;
            coreState_reg.pol <= POLARITY_RESET;
            coreState_reg.dir <= DIRECTION_RESET;
            coreState_reg.snap <= SNAPSHOT_RESET;
            coreState_reg.pinOut <= OUTPUT_RESET;
        end
        else
        begin
            coreState_reg <= coreState_next;
        end
    end

    // Outputs straight from the state register; the alert only ever pulls low.
    assign expanderPinsOut = coreState_reg.pinOut;
    assign expanderPinsOe = coreState_reg.pinOe;
    assign highSideDriver = coreState_reg.hi;
    assign lowSideDriver = coreState_reg.lo;
    assign alertOut = 1'b0;
    assign alertOe = coreState_reg.alertOe;
    assign readByte = coreState_reg.rd;

    // Checks on the core clock.
    default clocking coreCk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_power_reset: assert property (!coreState_reg.thr[1] |=> coreState_reg.coreRst && !alertOe)
        else $error("Core left reset while supply was below threshold.");
    a_inputs_at_reset: assert property (!coreState_reg.thr[1] |=> expanderPinsOe == 8'h00)
        else $error("A pin drives during power reset.");
    a_input_off: assert property (((highSideDriver | lowSideDriver) & ~expanderPinsOe) == 8'h00)
        else $error("A driver is on for an input pin.");
    a_output_drive: assert property (highSideDriver == (expanderPinsOut & expanderPinsOe)
        && lowSideDriver == (~expanderPinsOut & expanderPinsOe))
        else $error("Output driver does not follow the output register.");
    a_change_alert: assert property (coreState_reg.thr[1] && coreState_reg.prime == PRIME_CYCLES
        && !clearEvent && |((coreState_reg.pin2 ^ coreState_reg.snap) & coreState_next.dir)
        |=> alertOe)
        else $error("Input change did not raise the alert.");
    a_return_clear: assert property (coreState_reg.thr[1] && coreState_reg.prime == PRIME_CYCLES
        && !clearEvent && ((coreState_reg.pin2 ^ coreState_reg.snap) & coreState_next.dir) == 8'h00
        |=> !alertOe)
        else $error("Alert stayed with pins back at snapshot.");
    a_read_clear: assert property (coreState_reg.thr[1] && coreState_reg.prime == PRIME_CYCLES
        && clearEvent |=> coreState_reg.snap == $past(coreState_reg.pin2) && !alertOe)
        else $error("Clearing read did not clear the alert.");
    a_other_traffic: assert property (coreState_reg.thr[1] && coreState_reg.prime == PRIME_CYCLES
        && !clearEvent |=> $stable(coreState_reg.snap))
        else $error("Snapshot moved without a clearing read.");
    a_output_quiet: assert property (coreState_next.dir == 8'h00 |=> !alertOe)
        else $error("Alert raised with all pins outputs.");
    a_alert_level: assert property (alertOut == 1'b0)
        else $error("Alert line driven high.");
    a_dir_write: assert property (coreState_reg.thr[1] && writeEvent && writeSelHeld == REG_DIRECTION
        |=> expanderPinsOe == ~$past(writeDataHeld))
        else $error("Direction write did not steer the pins.");
    a_input_read: assert property (coreState_reg.thr[1] && coreState_next.ptr == REG_INPUT
        |=> readByte == $past(reportedInput))
        else $error("Input read-back is not the live pin value.");

    // Pointer copy and register writes.
    a_ptr_steady: assert property (coreState_reg.thr[1]
        && !pointerEvent
        |=> $stable(coreState_reg.ptr))
        else $error("Read-back pointer moved without a command.");

    a_ptr_load: assert property (coreState_reg.thr[1]
        && pointerEvent
        |=> coreState_reg.ptr == $past(pointerHeld))
        else $error("Read-back pointer missed a command.");

    a_out_write: assert property (coreState_reg.thr[1]
        && writeEvent && writeSelHeld == REG_OUTPUT
        |=> expanderPinsOut == $past(writeDataHeld))
        else $error("Output write did not reach the pins.");

    a_pol_write: assert property (coreState_reg.thr[1]
        && writeEvent && writeSelHeld == REG_POLARITY
        |=> coreState_reg.pol == $past(writeDataHeld))
        else $error("Polarity write was not stored.");

    a_input_write: assert property (coreState_reg.thr[1]
        && writeEvent && writeSelHeld == REG_INPUT
        |=> $stable(coreState_reg.outv) && $stable(coreState_reg.pol) && $stable(coreState_reg.dir))
        else $error("Write to the input register changed a register.");

    // Read-back of the other registers and power-up values.
    a_out_read: assert property (coreState_reg.thr[1]
        && coreState_next.ptr == REG_OUTPUT
        |=> readByte == expanderPinsOut)
        else $error("Output read-back differs from the pins.");

    a_dir_read: assert property (coreState_reg.thr[1]
        && coreState_next.ptr == REG_DIRECTION
        |=> readByte == ~expanderPinsOe)
        else $error("Direction read-back differs from the pins.");

    a_plain_read: assert property (coreState_reg.thr[1]
        && coreState_next.ptr == REG_INPUT && coreState_next.pol == 8'h00
        |=> readByte == $past(coreState_reg.pin2))
        else $error("Input read-back without inversion is not the pin level.");

    a_power_values: assert property (!coreState_reg.thr[1]
        |=> expanderPinsOut == OUTPUT_RESET && coreState_reg.pol == POLARITY_RESET
        && coreState_reg.ptr == REG_INPUT)
        else $error("Registers left power-up values under a low supply.");

    // Alert around priming and direction changes, and driver exclusion.
    a_prime_quiet: assert property (coreState_reg.prime != PRIME_CYCLES
        |=> !alertOe)
        else $error("Alert raised while the snapshot was priming.");

    a_switch_alert: assert property (coreState_reg.thr[1] && coreState_reg.prime == PRIME_CYCLES
        && !clearEvent && writeEvent && writeSelHeld == REG_DIRECTION
        && |((coreState_reg.pin2 ^ coreState_reg.snap) & writeDataHeld)
        |=> alertOe)
        else $error("Switch to input with a changed level did not alert.");

    a_drivers_apart: assert property ((highSideDriver & lowSideDriver) == 8'h00)
        else $error("Both drivers of a pin are on.");

    c_alert_rise: cover property ($rose(alertOe));
    c_read_clear: cover property (alertOe ##1 clearEvent ##1 !alertOe);
    c_rearm: cover property (clearEvent ##[1:50] $rose(alertOe));
    c_switch_input: cover property ($rose(expanderPinsOe == 8'h00) ##[1:50] $rose(alertOe));
endmodule

`default_nettype wire

/* File: tb/ioex_bus_master.sv */
`default_nettype none

// Behavioural serial master: runs the link clock only while one of its tasks runs.
module ioex_bus_master
(
    // Link clock and serial engine events.
    output logic sclClk,
    output logic cmdStrobe,
    output logic [7:0] cmdByte,
    output logic dataStrobe,
    output logic [7:0] dataByte,
    output logic ownReadAck,
    output logic foreignReadAck
);
    timeunit 1ns;
    timeprecision 1ps;

    // The link clock rests low and the bytes start at arbitrary levels.
    initial
    begin
        sclClk = 1'b0;
        cmdStrobe = 1'b0;
        dataStrobe = 1'b0;
        ownReadAck = 1'b0;
        foreignReadAck = 1'b0;
        cmdByte = 8'h00;
        dataByte = 8'hFF;
    end

    // Runs n link clock periods of 160 ns, ending low, with rising edges off the core clock edges.
    task automatic idle(input int n);
        repeat (n)
        begin
            #83 sclClk = 1'b1;
            #77 sclClk = 1'b0;
        end
    endtask

    // Kind is one-hot: command, data, own read acknowledge, foreign read acknowledge.
    task automatic send(input logic [3:0] kind, input logic [7:0] val);
        cmdStrobe = kind[3];
        dataStrobe = kind[2];
        ownReadAck = kind[1];
        foreignReadAck = kind[0];
        if (kind[3])
            cmdByte = val;
        if (kind[2])
            dataByte = val;
        idle(1);
        // Released bytes show the inverse so stale values never look valid.
        cmdStrobe = 1'b0;
        dataStrobe = 1'b0;
        ownReadAck = 1'b0;
        foreignReadAck = 1'b0;
        cmdByte = ~cmdByte;
        dataByte = ~dataByte;
        idle(2);
    endtask

    // The low two bits of the command byte select the register.
    task automatic set_ptr(input logic [1:0] p);
        send(4'h8, {6'h00, p});
    endtask

    // A register write is a command byte followed by one data byte.
    task automatic write_reg(input logic [1:0] p, input logic [7:0] v);
        set_ptr(p);
        send(4'h4, v);
    endtask
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none

// Self-checking bench of the port expander core.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ioex_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic powerOnThreshold = 1'b0;
    logic [7:0] expanderPinsIn = 8'h3C;
    logic sclClk, cmdStrobe, dataStrobe, ownReadAck, foreignReadAck, alertOut, alertOe;
    logic [7:0] cmdByte, dataByte, expanderPinsOut, expanderPinsOe, highSideDriver, lowSideDriver, readByte;
    int err_total = 0;
    int cmp_count = 0;

    // Core clock of 100 MHz.
    always #5 clk = ~clk;

    ioex_bus_master bm (.sclClk(sclClk), .cmdStrobe(cmdStrobe), .cmdByte(cmdByte), .dataStrobe(dataStrobe),
        .dataByte(dataByte), .ownReadAck(ownReadAck), .foreignReadAck(foreignReadAck));

    ioex_port_alert DUT (.clk(clk), .reset_n(reset_n), .powerOnThreshold(powerOnThreshold), .sclClk(sclClk),
        .cmdStrobe(cmdStrobe), .cmdByte(cmdByte), .dataStrobe(dataStrobe), .dataByte(dataByte),
        .ownReadAck(ownReadAck), .foreignReadAck(foreignReadAck), .expanderPinsIn(expanderPinsIn),
        .expanderPinsOut(expanderPinsOut), .expanderPinsOe(expanderPinsOe), .highSideDriver(highSideDriver),
        .lowSideDriver(lowSideDriver), .alertOut(alertOut), .alertOe(alertOe), .readByte(readByte));

    // Compares one value and counts it.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Waits n falling edges, where outputs are settled.
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Moves the pins on a rising edge.
    task automatic set_pins(input logic [7:0] v);
        @(posedge clk);
        expanderPinsIn <= v;
    endtask

    // Waits a bounded time for the alert level, then judges it and the open-drain data.
    task automatic expect_alert(input logic want, input string what);
        for (int i = 0; i < 40 && alertOe !== want; i++)
            @(negedge clk);
        check(what, {7'h00, alertOe}, {7'h00, want});
        check("alertOut", {7'h00, alertOut}, 8'h00);
    endtask

    // Power-up values while the supply is below threshold.
    task automatic test_reset_values();
        settle(2);
        check("pinsOe", expanderPinsOe, 8'h00);
        check("highSide", highSideDriver, 8'h00);
        check("lowSide", lowSideDriver, 8'h00);
        check("pinsOut", expanderPinsOut, OUTPUT_RESET);
        check("alertOe", {7'h00, alertOe}, 8'h00);
        check("alertOut", {7'h00, alertOut}, 8'h00);
    endtask

    // Outputs on the upper nibble, driver choice from the output register.
    task automatic test_drive();
        bm.write_reg(2'h1, 8'hA5);
        bm.write_reg(2'h3, 8'h0F);
        settle(6);
        check("pinsOe", expanderPinsOe, 8'hF0);
        check("highSide", highSideDriver, 8'hA0);
        check("lowSide", lowSideDriver, 8'h50);
        check("pinsOut", expanderPinsOut, 8'hA5);
        check("readDir", readByte, 8'h0F);
        bm.set_ptr(2'h1);
        settle(6);
        check("readOut", readByte, 8'hA5);
    endtask

    // Output pins stay silent, input edges alert, returning pins clear it.
    task automatic test_change();
        set_pins(8'hBC);
        settle(10);
        check("outputNoAlert", {7'h00, alertOe}, 8'h00);
        set_pins(8'hBD);
        expect_alert(1'b1, "riseAlert");
        set_pins(8'hBC);
        expect_alert(1'b0, "returnClear");
        set_pins(8'hB8);
        expect_alert(1'b1, "fallAlert");
        set_pins(8'hBC);
        expect_alert(1'b0, "returnClear2");
    endtask

    // Reads and clears, the pointer flaw, traffic of others and direction switch.
    task automatic test_read_clear();
        bm.write_reg(2'h2, 8'h03);
        bm.set_ptr(2'h0);
        set_pins(8'hBD);
        expect_alert(1'b1, "alertBeforeRead");
        settle(4);
        check("readInput", readByte, 8'hBE);
        bm.send(4'h2, 8'h00);
        expect_alert(1'b0, "readClear");
        set_pins(8'hBF);
        expect_alert(1'b1, "reAlert");
        bm.send(4'h1, 8'h00);
        expect_alert(1'b0, "foreignClear");
        bm.set_ptr(2'h1);
        set_pins(8'hBB);
        expect_alert(1'b1, "alertPtrOne");
        bm.send(4'h1, 8'h00);
        bm.write_reg(2'h2, 8'h00);
        settle(10);
        check("foreignKeeps", {7'h00, alertOe}, 8'h01);
        set_pins(8'hBF);
        expect_alert(1'b0, "returnClear3");
        set_pins(8'hAF);
        settle(10);
        check("outputNoAlert2", {7'h00, alertOe}, 8'h00);
        bm.write_reg(2'h3, 8'hFF);
        expect_alert(1'b1, "switchAlert");
        check("pinsOeIn", expanderPinsOe, 8'h00);
    endtask

    // Watchdog reckoned at about twenty times the expected run length.
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    // Reset, link start-up under a low supply, then the scenarios.
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        bm.idle(4);
        test_reset_values();
        @(posedge clk);
        powerOnThreshold <= 1'b1;
        bm.idle(5);
        settle(4);
        test_drive();
        test_change();
        test_read_clear();
        tally_and_finish();
    end
endmodule

`default_nettype wire
